//--- include/billboard_pkg.sv
// constants and types for the billboard fallback controller
package billboard_pkg;
    // core clock and time base
    localparam int unsigned CLOCK_HZ      = 10_000_000;
    localparam int unsigned TICK_MS       = 10;
    localparam int unsigned TICK_CYCLES   = CLOCK_HZ / 1000 * TICK_MS;
    localparam int unsigned DETACH_US     = 100;
    localparam int unsigned DETACH_CYCLES = CLOCK_HZ / 1_000_000 * DETACH_US;
    localparam int unsigned DETACH_CW     = $clog2(DETACH_CYCLES + 1);

    // register bus
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam logic [15:0] ADDR_TIMER_A_LOW  = 16'h413C;
    localparam logic [15:0] ADDR_TIMER_A_HIGH = 16'h413D;
    localparam logic [15:0] ADDR_TIMER_B_LOW  = 16'h413E;
    localparam logic [15:0] ADDR_TIMER_B_HIGH = 16'h413F;
    localparam logic [15:0] ADDR_CONFIG       = 16'h4140;
    localparam logic [15:0] ADDR_STATUS       = 16'h4141;

    // reset values
    localparam logic [7:0] RST_TIMER_A_LOW  = 8'hD0;
    localparam logic [7:0] RST_TIMER_A_HIGH = 8'h07;
    localparam logic [7:0] RST_TIMER_B_LOW  = 8'hD0;
    localparam logic [7:0] RST_TIMER_B_HIGH = 8'h07;
    localparam logic [7:0] RST_CONFIG       = 8'h14;

    // billboard_config fields
    localparam int unsigned CFG_EN_BIT  = 0;
    localparam int unsigned CFG_SEL_LSB = 1;
    localparam int unsigned CFG_SEL_MSB = 5;
    localparam logic [7:0]  CFG_RW_MASK = 8'h3F;

    // pin select codes
    localparam int unsigned NUM_PINS          = 16;
    localparam logic [4:0]  PIN_CODE_RESERVED = 5'h09;
    localparam logic [4:0]  PIN_CODE_DEFAULT  = 5'h0A;
    localparam logic [4:0]  PIN_CODE_LAST     = 5'h10;
    localparam logic [3:0]  DEFAULT_FAIL_PIN  = 4'h9;

    // status register bits
    localparam int unsigned ST_BILLBOARD = 0;
    localparam int unsigned ST_DETACHED  = 1;
    localparam int unsigned ST_TIMER_A   = 2;
    localparam int unsigned ST_TIMER_B   = 3;
    localparam int unsigned ST_PIN_LOW   = 4;

    // descriptor facts handed to the function
    localparam logic [15:0] BB_CLASS_VERSION = 16'h0110;
    localparam logic [1:0]  CFG_STATUS_UNSPEC = 2'h0;

    typedef enum logic [1:0] {
        ST_STANDARD,
        ST_DETACH_TO_BB,
        ST_BB_ATTACHED,
        ST_DETACH_TO_STD
    } seq_state_t;
endpackage : billboard_pkg

//--- hdl/billboard_fallback_control.sv
// billboard fallback enumeration control with detach timers
//
// Contract
// (RULE_01) fallback acts only while config bit 0 is set
// (RULE_02) config bits 5:1 pick the fail input, code 01010 the default pin
// (RULE_03) any listed pin can serve; default pin used when unchanged
// (RULE_04) selected fail input is active low
// (RULE_05) external controller drives the pin low on mode failure
// (RULE_06) on failure the internal function is first detached
// (RULE_07) it then reattaches with billboard class 1.1 descriptors
// (RULE_08) timer A starts when the host assigns the function address
// (RULE_09) billboard shown only after failure; configured status reads 00b
// (RULE_10) alternate mode string request starts timer B
// (RULE_11) expiry of either timer detaches the function
// (RULE_12) it then reattaches with standard descriptors
// (RULE_13) each timer loads 16 bits from low and high bytes, 10 ms steps
// (RULE_14) timer A resets to D0h low and 07h high, 20 s
// (RULE_15) timer B defaults to 20 s
// (RULE_16) billboard_config resets to 14h: default pin, disabled
// (RULE_17) failure message text comes from one-time-programmable storage; this design holds no such storage, only o_billboard_desc is driven
// (RULE_18) hub only reacts to the failure signal, no negotiation
// (RULE_19) 10 ms tick from a prescaler; failure input ignored mid-sequence
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module billboard_fallback_control
    import billboard_pkg::*;
#(
    parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    input  wire logic [NUM_PINS-1:0] i_general_pin_n,
    input  wire logic                i_addr_assigned,
    input  wire logic                i_alt_string_req,
    input  wire logic [ADDR_W-1:0]   i_reg_addr,
    input  wire logic [DATA_W-1:0]   i_reg_wdata,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    output logic      [DATA_W-1:0]   o_reg_rdata,
    output logic                     o_function_detach,
    output logic                     o_billboard_desc,
    output logic      [15:0]         o_class_version,
    output logic      [1:0]          o_configured_status
);

    localparam int unsigned PRE_W = $clog2(TICK_COUNT + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_COUNT - 1);
    localparam logic [DETACH_CW-1:0] DETACH_LAST =
        DETACH_CW'(DETACH_CYCLES - 1);

    // registers
    logic [7:0]  timer_a_low_r;
    logic [7:0]  timer_a_high_r;
    logic [7:0]  timer_b_low_r;
    logic [7:0]  timer_b_high_r;
    logic [7:0]  config_r;

    // pin path
    logic [NUM_PINS-1:0] pin_meta_r;
    logic [NUM_PINS-1:0] pin_sync_r;
    logic                fail_low;
    logic                armed_r;
    logic                trigger;

    // sequencer
    seq_state_t           state_r;
    seq_state_t           state_nxt;
    logic [DETACH_CW-1:0] hold_r;
    logic                 hold_done;

    // timers
    logic [1:0]  tmr_start;
    logic [1:0]  tmr_run;
    logic [1:0]  tmr_expire;
    logic [15:0] tmr_load [2];
    logic        any_expire;

    // two-stage synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    pin_meta_r[gi] <= 1'b1;
                    pin_sync_r[gi] <= 1'b1;
                end else begin
                    pin_meta_r[gi] <= i_general_pin_n[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    // code to pin slot; reserved and unlisted codes read inactive
    function automatic logic sel_pin_low(input logic [4:0] code,
                                         input logic [NUM_PINS-1:0] pins);
        logic [4:0] slot;
        logic       low;
        slot = 5'h00;
        low  = 1'b0;
        if (code < PIN_CODE_RESERVED) begin
            slot = code;
            low  = ~pins[slot[3:0]];
        end else if (code > PIN_CODE_RESERVED && code <= PIN_CODE_LAST) begin
            slot = code - 5'h01;
            low  = ~pins[slot[3:0]];
        end
        return low;
    endfunction : sel_pin_low

    // (RULE_02) pin select decode
    // (RULE_03) default code maps to default slot
    // (RULE_04) active low input
    assign fail_low = sel_pin_low(config_r[CFG_SEL_MSB:CFG_SEL_LSB],
                                  pin_sync_r);

    // (RULE_01) gated by enable
    // (RULE_19) ignored unless idle and armed
    assign trigger = config_r[CFG_EN_BIT] && fail_low && armed_r &&
                     (state_r == ST_STANDARD);

    // re-arm only after the pin has been seen released while idle
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            armed_r <= 1'b1;
        end else if (trigger) begin
            armed_r <= 1'b0;
        end else if (state_r == ST_STANDARD && !fail_low) begin
            armed_r <= 1'b1;
        end
    end

    // register writes
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            // (RULE_14) timer A reset value
            timer_a_low_r  <= RST_TIMER_A_LOW;
            timer_a_high_r <= RST_TIMER_A_HIGH;
            // (RULE_15) timer B default 20 s
            timer_b_low_r  <= RST_TIMER_B_LOW;
            timer_b_high_r <= RST_TIMER_B_HIGH;
            // (RULE_16) config reset value
            config_r       <= RST_CONFIG;
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                ADDR_TIMER_A_LOW:  timer_a_low_r  <= i_reg_wdata;
                ADDR_TIMER_A_HIGH: timer_a_high_r <= i_reg_wdata;
                ADDR_TIMER_B_LOW:  timer_b_low_r  <= i_reg_wdata;
                ADDR_TIMER_B_HIGH: timer_b_high_r <= i_reg_wdata;
                ADDR_CONFIG:       config_r <= i_reg_wdata & CFG_RW_MASK;
                default: ;
            endcase
        end
    end

    // register reads, data in the following cycle only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_TIMER_A_LOW:  o_reg_rdata <= timer_a_low_r;
                ADDR_TIMER_A_HIGH: o_reg_rdata <= timer_a_high_r;
                ADDR_TIMER_B_LOW:  o_reg_rdata <= timer_b_low_r;
                ADDR_TIMER_B_HIGH: o_reg_rdata <= timer_b_high_r;
                ADDR_CONFIG:       o_reg_rdata <= config_r;
                ADDR_STATUS: begin
                    o_reg_rdata <= 8'h00;
                    o_reg_rdata[ST_BILLBOARD] <= o_billboard_desc;
                    o_reg_rdata[ST_DETACHED]  <= o_function_detach;
                    o_reg_rdata[ST_TIMER_A]   <= tmr_run[0];
                    o_reg_rdata[ST_TIMER_B]   <= tmr_run[1];
                    o_reg_rdata[ST_PIN_LOW]   <= fail_low;
                end
                default:           o_reg_rdata <= 8'h00;
            endcase
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // (RULE_13) 16-bit load from byte pairs
    assign tmr_load[0] = {timer_a_high_r, timer_a_low_r};
    assign tmr_load[1] = {timer_b_high_r, timer_b_low_r};

    // (RULE_08) address assignment starts timer A
    // (RULE_10) string request starts timer B
    assign tmr_start[0] = i_addr_assigned && state_r == ST_BB_ATTACHED;
    assign tmr_start[1] = i_alt_string_req && state_r == ST_BB_ATTACHED;

    // detach timers, each with its own 10 ms prescaler
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            logic [PRE_W-1:0] pre_r;
            logic [15:0]      cnt_r;
            logic             tick;

            // (RULE_19) 10 ms prescaler
            assign tick = (pre_r == PRE_LAST);

            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    pre_r <= '0;
                end else if (tmr_start[gi] || !tmr_run[gi] || tick) begin
                    pre_r <= '0;
                end else begin
                    pre_r <= pre_r + PRE_W'(1);
                end
            end

            // (RULE_13) one count per 10 ms
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    cnt_r       <= 16'h0000;
                    tmr_run[gi] <= 1'b0;
                end else if (state_r != ST_BB_ATTACHED) begin
                    cnt_r       <= 16'h0000;
                    tmr_run[gi] <= 1'b0;
                end else if (tmr_start[gi]) begin
                    cnt_r       <= tmr_load[gi];
                    tmr_run[gi] <= 1'b1;
                end else if (tmr_run[gi] && tick) begin
                    cnt_r <= (cnt_r == 16'h0000) ? 16'h0000
                                                 : cnt_r - 16'h0001;
                end
            end

            // zero load expires on the first tick
            assign tmr_expire[gi] = tmr_run[gi] && tick &&
                                    cnt_r <= 16'h0001;
        end
    endgenerate

    // (RULE_11) either timer ends billboard mode
    assign any_expire = |tmr_expire;

    // detach hold time
    assign hold_done = (hold_r == DETACH_LAST);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            hold_r <= '0;
        end else if (state_nxt != state_r) begin
            hold_r <= '0;
        end else if (!hold_done) begin
            hold_r <= hold_r + DETACH_CW'(1);
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            // (RULE_18) only the failure level is observed
            ST_STANDARD: begin
                if (trigger) begin
                    state_nxt = ST_DETACH_TO_BB;
                end
            end
            ST_DETACH_TO_BB: begin
                if (hold_done) begin
                    state_nxt = ST_BB_ATTACHED;
                end
            end
            ST_BB_ATTACHED: begin
                if (any_expire) begin
                    state_nxt = ST_DETACH_TO_STD;
                end
            end
            ST_DETACH_TO_STD: begin
                if (hold_done) begin
                    state_nxt = ST_STANDARD;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_STANDARD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // (RULE_06) detach before billboard attach
    // (RULE_11) detach after timer expiry
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_function_detach <= 1'b0;
        end else begin
            o_function_detach <= (state_nxt == ST_DETACH_TO_BB) ||
                                 (state_nxt == ST_DETACH_TO_STD);
        end
    end

    // (RULE_07) billboard descriptors on reattach
    // (RULE_09) exposed only after a failure
    // (RULE_12) standard descriptors after timer detach
    // (RULE_17) no OTP message text is held here; only the billboard descriptor flag is driven
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_billboard_desc <= 1'b0;
        end else begin
            o_billboard_desc <= (state_nxt == ST_BB_ATTACHED);
        end
    end

    // (RULE_07) class revision 1.1
    // (RULE_09) configured status unspecified error
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_class_version     <= BB_CLASS_VERSION;
            o_configured_status <= CFG_STATUS_UNSPEC;
        end else begin
            o_class_version     <= BB_CLASS_VERSION;
            o_configured_status <= CFG_STATUS_UNSPEC;
        end
    end

endmodule : billboard_fallback_control

//--- tb/billboard_properties.sv
// assertions for the billboard fallback controller
`timescale 1ns/100ps
module billboard_properties
    import billboard_pkg::*;
#(
    parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
    input wire logic                i_clock,
    input wire logic                i_rst,
    input wire logic [NUM_PINS-1:0] i_general_pin_n,
    input wire logic                i_addr_assigned,
    input wire logic                i_alt_string_req,
    input wire logic [ADDR_W-1:0]   i_reg_addr,
    input wire logic [DATA_W-1:0]   i_reg_wdata,
    input wire logic                i_reg_wr,
    input wire logic                i_reg_rd,
    input wire logic [DATA_W-1:0]   o_reg_rdata,
    input wire logic                o_function_detach,
    input wire logic                o_billboard_desc,
    input wire logic [15:0]         o_class_version,
    input wire logic [1:0]          o_configured_status
);
    logic [15:0] det_cnt_r;
    logic        started_r;
    int unsigned since_r;
    // cycles in detach, timer start seen, cycles since start
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            det_cnt_r <= '0;
            started_r <= 1'b0;
            since_r   <= 0;
        end else begin
            det_cnt_r <= o_function_detach ? det_cnt_r + 16'h1 : 16'h0;
            started_r <= o_billboard_desc &
                         (started_r | i_addr_assigned | i_alt_string_req);
            since_r   <= (i_addr_assigned | i_alt_string_req) ? 0 : since_r + 1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_leave_bb; $fell(o_billboard_desc); endsequence
    property p_hold; $fell(o_function_detach) |-> det_cnt_r == DETACH_CYCLES;
    endproperty
    property p_to_bb; $rose(o_billboard_desc) |->
        $past(o_function_detach) && !o_function_detach; endproperty
    property p_exit; s_leave_bb |-> o_function_detach; endproperty
    property p_cause; s_leave_bb |->
        $past(started_r) && $past(since_r) >= TICK_COUNT - 1; endproperty
    property p_excl; !(o_function_detach && o_billboard_desc); endproperty
    property p_pin; $rose(o_function_detach) && !$past(o_billboard_desc) |->
        $past(i_general_pin_n, 2) != {NUM_PINS{1'b1}}; endproperty
    property p_ver; o_class_version == BB_CLASS_VERSION; endproperty
    property p_cst; o_configured_status == CFG_STATUS_UNSPEC; endproperty
    property p_rd; !$past(i_reg_rd) |-> o_reg_rdata == 8'h00; endproperty
    a_hold: assert property (p_hold)
        else $error("detach hold length wrong");
    a_to_bb: assert property (p_to_bb)
        else $error("billboard attach not after detach");
    a_exit: assert property (p_exit)
        else $error("billboard left without detach");
    a_cause: assert property (p_cause)
        else $error("billboard left without timer run");
    a_excl: assert property (p_excl)
        else $error("detach and billboard both high");
    a_pin: assert property (p_pin)
        else $error("detach without low pin");
    a_ver: assert property (p_ver)
        else $error("class version wrong");
    a_cst: assert property (p_cst)
        else $error("configured status wrong");
    a_rd: assert property (p_rd)
        else $error("read data outside read slot");
endmodule : billboard_properties

bind billboard_fallback_control billboard_properties #(
    .TICK_COUNT(TICK_COUNT)
) i_billboard_properties (
    .i_clock(i_clock), .i_rst(i_rst), .i_general_pin_n(i_general_pin_n),
    .i_addr_assigned(i_addr_assigned), .i_alt_string_req(i_alt_string_req),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_function_detach(o_function_detach), .o_billboard_desc(o_billboard_desc),
    .o_class_version(o_class_version),
    .o_configured_status(o_configured_status)
);

//--- tb/pd_fail_source.sv
// failure-signal source in place of the power delivery controller
`timescale 1ns/100ps
module pd_fail_source
    import billboard_pkg::*;
(
    input  wire logic                i_fail,
    input  wire logic [3:0]          i_slot,
    output logic      [NUM_PINS-1:0] o_general_pin_n
);
    assign o_general_pin_n = i_fail ? ~(16'h0001 << i_slot) : 16'hFFFF;
endmodule : pd_fail_source

//--- tb/testbench.sv
// self-checking bench for the billboard fallback controller
`timescale 1ns/100ps
module testbench;
    import billboard_pkg::*;
    localparam int unsigned TK = 20;
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_addr_assigned = 1'b0;
    logic        i_alt_string_req = 1'b0;
    logic [15:0] i_reg_addr = 16'h0000;
    logic [7:0]  i_reg_wdata = 8'h00;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic        fail = 1'b0;
    logic [3:0]  slot = 4'h9;
    logic [15:0] pins_n;
    logic [7:0]  o_reg_rdata;
    logic        o_function_detach;
    logic        o_billboard_desc;
    logic [15:0] o_class_version;
    logic [1:0]  o_configured_status;
    int          n_fail = 0;
    int          n_compared = 0;
    logic [15:0] ra [7] = '{16'h413C, 16'h413D, 16'h413E, 16'h413F,
                            16'h4140, 16'h4142, 16'h4100};
    logic [7:0]  re [7] = '{8'hD0, 8'h07, 8'hD0, 8'h07, 8'h14, 8'h00, 8'h00};

    always #50 i_clock = ~i_clock;

    pd_fail_source i_pd_fail_source (
        .i_fail(fail), .i_slot(slot), .o_general_pin_n(pins_n));
    billboard_fallback_control #(
        .TICK_COUNT(TK)
    ) i_billboard_fallback_control (
        .i_clock(i_clock), .i_rst(i_rst), .i_general_pin_n(pins_n),
        .i_addr_assigned(i_addr_assigned),
        .i_alt_string_req(i_alt_string_req),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .o_function_detach(o_function_detach),
        .o_billboard_desc(o_billboard_desc), .o_class_version(o_class_version),
        .o_configured_status(o_configured_status));

    task automatic give_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_clock);
        i_reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clock);
        i_reg_rd   <= 1'b0;
        #1;
        cmp("rdata", {8'h00, e}, {8'h00, o_reg_rdata});
    endtask : rd

    // waits for detach and billboard levels, returns cycles taken
    task automatic wait_for(input logic d, input logic b, input int lim,
                            output int k);
        k = 0;
        while ({o_function_detach, o_billboard_desc} !== {d, b} && k < lim)
        begin
            @(posedge i_clock);
            #1;
            k++;
        end
        cmp("state", {14'h0, d, b},
            {14'h0, o_function_detach, o_billboard_desc});
    endtask : wait_for

    task automatic fallback(input logic [4:0] code, input logic [3:0] sl,
                            input logic use_b, input logic [7:0] n);
        int k;
        wr(ADDR_CONFIG, {2'b00, code, 1'b1});
        wr(use_b ? ADDR_TIMER_B_LOW : ADDR_TIMER_A_LOW, n);
        wr(use_b ? ADDR_TIMER_B_HIGH : ADDR_TIMER_A_HIGH, 8'h00);
        @(posedge i_clock);
        slot <= sl;
        fail <= 1'b1;
        wait_for(1'b1, 1'b0, 10, k);
        wait_for(1'b0, 1'b1, DETACH_CYCLES + 5, k);
        @(posedge i_clock);
        i_alt_string_req <= use_b;
        i_addr_assigned  <= !use_b;
        @(posedge i_clock);
        i_alt_string_req <= 1'b0;
        i_addr_assigned  <= 1'b0;
        rd(ADDR_STATUS, use_b ? 8'h19 : 8'h15);
        wait_for(1'b1, 1'b0, n * TK + 10, k);
        // status read took two edges of the timer run
        k = k + 2;
        cmp("ticks", 16'h1, 16'(k inside {[n*TK-1 : n*TK+2]}));
        wait_for(1'b0, 1'b0, DETACH_CYCLES + 5, k);
        repeat (30) @(posedge i_clock);
        cmp("rearm", 16'h0, {15'h0, o_function_detach});
        fail <= 1'b0;
        repeat (4) @(posedge i_clock);
    endtask : fallback

    initial begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], re[i]);
        end
        wr(ADDR_CONFIG, 8'hFF);
        rd(ADDR_CONFIG, 8'h3F);
        wr(ADDR_STATUS, 8'hFF);
        wr(ADDR_CONFIG, 8'h14);
        rd(ADDR_STATUS, 8'h00);
        @(posedge i_clock);
        fail <= 1'b1;
        repeat (30) @(posedge i_clock);
        cmp("disabled", 16'h0, {15'h0, o_function_detach});
        // enabled with the reserved code: no pin may be taken
        wr(ADDR_CONFIG, 8'h13);
        repeat (30) @(posedge i_clock);
        cmp("reserved", 16'h0, {15'h0, o_function_detach});
        fail <= 1'b0;
        fallback(5'h0A, 4'h9, 1'b0, 8'h03);
        fallback(5'h0F, 4'hE, 1'b1, 8'h02);
        fallback(5'h03, 4'h3, 1'b0, 8'h01);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        rd(ADDR_CONFIG, 8'h14);
        rd(ADDR_TIMER_B_LOW, 8'hD0);
        rd(ADDR_TIMER_A_HIGH, 8'h07);
        give_verdict();
    end
endmodule : testbench
